// File: logic/board_decode_cfg.svh
// Address map, I/O ranges and register offsets for the board address decoder.
// Assumes a 20-bit memory address and a 10-bit I/O address from the processor bus.
`ifndef BOARD_DECODE_CFG_SVH
`define BOARD_DECODE_CFG_SVH

`define MEM_TOP_BASE      20'hf0000
`define MEM_SOCK_BASE     20'hd0000
`define MEM_SOCK_LAST     20'heffff
`define MEM_OPT_BASE      20'hc8000
`define MEM_OPT_LAST      20'hcffff
`define MEM_VROM_BASE     20'hc0000
`define MEM_VROM_LAST     20'hc7fff
`define MEM_VIDEO_BASE    20'ha0000
`define MEM_VIDEO_LAST    20'hbffff
`define MEM_HIGH_DRAM     20'h80000
`define MEM_HIGH_LAST     20'h9ffff
`define MEM_LOW_LAST      20'h7ffff

`define IO_DMA1_LO        10'h000
`define IO_DMA1_HI        10'h00f
`define IO_PIC1_LO        10'h020
`define IO_PIC1_HI        10'h021
`define IO_CFG_INDEX      10'h022
`define IO_CFG_DATA       10'h023
`define IO_PIT_LO         10'h040
`define IO_PIT_HI         10'h043
`define IO_CTRL_STAT      10'h061
`define IO_PAGE_LO        10'h080
`define IO_PAGE_HI        10'h08f
`define IO_SYS_CTRL       10'h092
`define IO_PIC2_LO        10'h0a0
`define IO_PIC2_HI        10'h0a1
`define IO_DMA2_LO        10'h0c0
`define IO_DMA2_HI        10'h0df
`define IO_SER2_LO        10'h2f8
`define IO_SER2_HI        10'h2ff
`define IO_UTILITY        10'h37c
`define IO_SER1_LO        10'h3f8
`define IO_SER1_HI        10'h3ff

// Config data index that holds the memory routing selections.
`define CFG_ROUTE_IDX     8'h01
// Route bits inside that byte: 1 selects the on-board target; ROUTE_DRAM_BIT is not read, dram_large routes the high DRAM window.
`define ROUTE_SOCK_BIT    0
`define ROUTE_OPT_BIT     1
`define ROUTE_VROM_BIT    2
`define ROUTE_VIDEO_BIT   3
`define ROUTE_DRAM_BIT    4
// Standard setting: second socket and optional ROM window on board.
`define ROUTE_RESET       8'h03
`define BYTE_ZERO         8'h00
`define BANK_ZERO         4'h0
`define BANK_LSB          0
`define BANK_MSB          3
// Receive lines idle at mark, so the synchronisers start there.
`define RXD_IDLE          2'h3
`define FIFO_DEPTH_STD    16

`endif

// File: logic/board_decode_pkg.sv
// Types shared by the board address decoder.
// Assumes nothing beyond the configuration header.
package board_decode_pkg;

  typedef enum logic [2:0] {
    TGT_DRAM   = 3'b000,
    TGT_BOOT   = 3'b001,
    TGT_SOCKET = 3'b010,
    TGT_EXPAN  = 3'b011
  } mem_target_t;

  typedef enum logic [3:0] {
    IO_NONE    = 4'b0000,
    IO_DMA     = 4'b0001,
    IO_PIC     = 4'b0010,
    IO_CFG     = 4'b0011,
    IO_PIT     = 4'b0100,
    IO_SER1    = 4'b0101,
    IO_SER2    = 4'b0110,
    IO_PAGE    = 4'b0111,
    IO_REG     = 4'b1000
  } io_target_t;

endpackage : board_decode_pkg

// File: logic/io_range_decode.sv
// Decoder of the fixed on-board I/O ranges.
// Assumes a 10-bit I/O address qualified by the caller.
`include "board_decode_cfg.svh"

module io_range_decode
  import board_decode_pkg::*;
(
  input  wire logic [9:0] io_addr,
  input  wire logic       ser1_enable,
  input  wire logic       ser2_enable,
  output io_target_t      io_target
);

  function automatic logic in_range(input logic [9:0] a, input logic [9:0] lo, input logic [9:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  always_comb begin
    io_target = IO_NONE;
    if (in_range(io_addr, `IO_DMA1_LO, `IO_DMA1_HI) || in_range(io_addr, `IO_DMA2_LO, `IO_DMA2_HI)) begin
      io_target = IO_DMA;
    end else if (in_range(io_addr, `IO_PAGE_LO, `IO_PAGE_HI)) begin
      io_target = IO_PAGE;
    end else if (in_range(io_addr, `IO_PIC1_LO, `IO_PIC1_HI) || in_range(io_addr, `IO_PIC2_LO, `IO_PIC2_HI)) begin
      io_target = IO_PIC;
    end else if (in_range(io_addr, `IO_CFG_INDEX, `IO_CFG_DATA)) begin
      io_target = IO_CFG;
    end else if (in_range(io_addr, `IO_PIT_LO, `IO_PIT_HI)) begin
      io_target = IO_PIT;
    end else if (in_range(io_addr, `IO_SER1_LO, `IO_SER1_HI) && ser1_enable) begin
      io_target = IO_SER1;
    end else if (in_range(io_addr, `IO_SER2_LO, `IO_SER2_HI) && ser2_enable) begin
      io_target = IO_SER2;
    end else if (io_addr == `IO_CTRL_STAT || io_addr == `IO_SYS_CTRL || io_addr == `IO_UTILITY) begin
      io_target = IO_REG;
    end
  end

endmodule : io_range_decode

// File: logic/board_address_decoder.sv
// Board address decoder: routes processor memory and I/O cycles to on-board targets or the expansion bus.
// Assumes one bus cycle is presented per strobe, with address and data stable while the strobe is high.
`include "board_decode_cfg.svh"

module board_address_decoder
  import board_decode_pkg::*;
#(
  parameter int SERIAL_FIFO_DEPTH = `FIFO_DEPTH_STD
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [19:0] mem_addr,
  input  wire logic        mem_cycle,
  input  wire logic [9:0]  io_addr,
  input  wire logic        io_cycle,
  input  wire logic        io_write,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_claim,
  output logic             sel_dram,
  output logic             sel_boot_rom,
  output logic             sel_second_socket,
  output logic             sel_expansion_mem,
  output logic             sel_expansion_io,
  output logic      [3:0]  socket_bank,
  output logic             sel_dma,
  output logic             sel_pic,
  output logic             sel_pit,
  output logic             sel_page,
  output logic             sel_first_serial_port,
  output logic             sel_second_serial_port,
  input  wire logic        ser1_link_enable,
  input  wire logic        ser2_link_enable,
  input  wire logic        dram_large,
  input  wire logic        ser1_uart_irq,
  input  wire logic        ser2_uart_irq,
  output logic             irq4,
  output logic             irq3,
  input  wire logic        ser2_uart_rts,
  input  wire logic        half_duplex_mode,
  output logic             ser2_driver_enable,
  output logic             ser2_receiver_enable,
  input  wire logic        ser1_rxd_pin,
  input  wire logic        ser2_rxd_pin,
  output logic      [1:0]  rxd_sync
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (SERIAL_FIFO_DEPTH != `FIFO_DEPTH_STD) begin : g_depth_check
    $error("serial FIFO depth must be 16");
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [7:0] cfg_index_ff, nxt_cfg_index;
  logic [7:0] route_ff, nxt_route;
  logic [7:0] ctrl_stat_ff, nxt_ctrl_stat;
  logic [7:0] sys_ctrl_ff, nxt_sys_ctrl;
  logic [7:0] utility_ff, nxt_utility;
  io_target_t io_target;
  logic       io_wr;

  io_range_decode u_io_range_decode (
    .io_addr     (io_addr),
    .ser1_enable (ser1_link_enable),
    .ser2_enable (ser2_link_enable),
    .io_target   (io_target)
  );

  assign io_wr = io_cycle && io_write;

  always_comb begin
    nxt_cfg_index = cfg_index_ff;
    nxt_route     = route_ff;
    nxt_ctrl_stat = ctrl_stat_ff;
    nxt_sys_ctrl  = sys_ctrl_ff;
    nxt_utility   = utility_ff;
    if (io_wr) begin
      if (io_addr == `IO_CFG_INDEX) begin
        nxt_cfg_index = io_wdata;
      end
      if (io_addr == `IO_CFG_DATA && cfg_index_ff == `CFG_ROUTE_IDX) begin
        nxt_route = io_wdata;
      end
      if (io_addr == `IO_CTRL_STAT) begin
        nxt_ctrl_stat = io_wdata;
      end
      if (io_addr == `IO_SYS_CTRL) begin
        nxt_sys_ctrl = io_wdata;
      end
      if (io_addr == `IO_UTILITY) begin
        nxt_utility = io_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_index_ff <= `BYTE_ZERO;
      route_ff     <= `ROUTE_RESET;
      ctrl_stat_ff <= `BYTE_ZERO;
      sys_ctrl_ff  <= `BYTE_ZERO;
      utility_ff   <= `BYTE_ZERO;
    end else begin
      cfg_index_ff <= nxt_cfg_index;
      route_ff     <= nxt_route;
      ctrl_stat_ff <= nxt_ctrl_stat;
      sys_ctrl_ff  <= nxt_sys_ctrl;
      utility_ff   <= nxt_utility;
    end
  end

  // Utility register is write only; its address is claimed on board and reads back as zero.
  always_comb begin
    io_rdata = `BYTE_ZERO;
    unique case (io_addr)
      `IO_CFG_INDEX: io_rdata = cfg_index_ff;
      `IO_CFG_DATA:  io_rdata = (cfg_index_ff == `CFG_ROUTE_IDX) ? route_ff : `BYTE_ZERO;
      `IO_CTRL_STAT: io_rdata = {ctrl_stat_ff[7:2], irq3, irq4};
      `IO_SYS_CTRL:  io_rdata = sys_ctrl_ff;
      default:       io_rdata = `BYTE_ZERO;
    endcase
  end

  // ****************************************************************
  // Memory routing
  // ****************************************************************
  mem_target_t mem_target;

  always_comb begin
    mem_target = TGT_EXPAN;
    if (mem_addr >= `MEM_TOP_BASE) begin
      mem_target = TGT_BOOT;
    end else if (mem_addr >= `MEM_SOCK_BASE && mem_addr <= `MEM_SOCK_LAST) begin
      mem_target = route_ff[`ROUTE_SOCK_BIT] ? TGT_SOCKET : TGT_EXPAN;
    end else if (mem_addr >= `MEM_OPT_BASE && mem_addr <= `MEM_OPT_LAST) begin
      mem_target = route_ff[`ROUTE_OPT_BIT] ? TGT_BOOT : TGT_EXPAN;
    end else if (mem_addr >= `MEM_VROM_BASE && mem_addr <= `MEM_VROM_LAST) begin
      mem_target = route_ff[`ROUTE_VROM_BIT] ? TGT_BOOT : TGT_EXPAN;
    end else if (mem_addr >= `MEM_VIDEO_BASE && mem_addr <= `MEM_VIDEO_LAST) begin
      mem_target = route_ff[`ROUTE_VIDEO_BIT] ? TGT_DRAM : TGT_EXPAN;
    end else if (mem_addr >= `MEM_HIGH_DRAM && mem_addr <= `MEM_HIGH_LAST) begin
      mem_target = dram_large ? TGT_DRAM : TGT_EXPAN;
    end else begin
      mem_target = TGT_DRAM;
    end
  end

  assign sel_dram          = mem_cycle && (mem_target == TGT_DRAM);
  assign sel_boot_rom      = mem_cycle && (mem_target == TGT_BOOT);
  assign sel_second_socket = mem_cycle && (mem_target == TGT_SOCKET);
  assign sel_expansion_mem = mem_cycle && (mem_target == TGT_EXPAN);
  assign socket_bank       = utility_ff[`BANK_MSB:`BANK_LSB];

  // ****************************************************************
  // I/O routing
  // ****************************************************************
  assign sel_dma                = io_cycle && (io_target == IO_DMA);
  assign sel_page               = io_cycle && (io_target == IO_PAGE);
  assign sel_pic                = io_cycle && (io_target == IO_PIC);
  assign sel_pit                = io_cycle && (io_target == IO_PIT);
  assign sel_first_serial_port  = io_cycle && (io_target == IO_SER1);
  assign sel_second_serial_port = io_cycle && (io_target == IO_SER2);
  assign io_claim               = io_cycle && (io_target != IO_NONE);
  assign sel_expansion_io       = io_cycle && (io_target == IO_NONE);

  // ****************************************************************
  // Serial port interrupts and line direction
  // ****************************************************************
  // A disabled port must not hold its line, so the expansion card may use it.
  assign irq4 = ser1_uart_irq && ser1_link_enable;
  assign irq3 = ser2_uart_irq && ser2_link_enable;

  // Full duplex keeps both directions open; half duplex follows RTS, so reset leaves it receiving.
  assign ser2_driver_enable   = half_duplex_mode ? ser2_uart_rts : 1'b1;
  assign ser2_receiver_enable = half_duplex_mode ? !ser2_uart_rts : 1'b1;

  // ****************************************************************
  // Receive pin synchronisers
  // ****************************************************************
  logic [1:0] rx_s1_ff, rx_s2_ff, rx_s3_ff, rxd_ff;
  logic [1:0] nxt_rxd;

  always_comb begin
    nxt_rxd = rxd_ff;
    for (int i = 0; i < 2; i++) begin
      if (rx_s2_ff[i] == rx_s3_ff[i]) begin
        nxt_rxd[i] = rx_s3_ff[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1_ff <= `RXD_IDLE;
      rx_s2_ff <= `RXD_IDLE;
      rx_s3_ff <= `RXD_IDLE;
      rxd_ff   <= `RXD_IDLE;
    end else begin
      rx_s1_ff <= {ser2_rxd_pin, ser1_rxd_pin};
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
      rxd_ff   <= nxt_rxd;
    end
  end

  assign rxd_sync = rxd_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_top_rom_fixed: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_cycle && mem_addr >= `MEM_TOP_BASE) |-> sel_boot_rom && !sel_expansion_mem)
    else $error("top 64K not routed to boot ROM");

  a_socket_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_cycle && mem_addr >= `MEM_SOCK_BASE && mem_addr <= `MEM_SOCK_LAST)
      |-> (sel_second_socket == route_ff[`ROUTE_SOCK_BIT]))
    else $error("socket window misrouted");

  a_opt_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_cycle && mem_addr >= `MEM_OPT_BASE && mem_addr <= `MEM_OPT_LAST)
      |-> (sel_boot_rom == route_ff[`ROUTE_OPT_BIT]))
    else $error("optional ROM window misrouted");

  a_vrom_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_cycle && mem_addr >= `MEM_VROM_BASE && mem_addr <= `MEM_VROM_LAST)
      |-> (sel_expansion_mem != route_ff[`ROUTE_VROM_BIT]))
    else $error("display ROM window misrouted");

  a_low_dram: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_cycle && mem_addr <= `MEM_LOW_LAST) |-> sel_dram)
    else $error("low memory not in DRAM");

  a_io_forward: assert property (@(posedge ref_clk) disable iff (!rst_b)
    io_cycle |-> (sel_expansion_io != io_claim))
    else $error("I/O cycle both claimed and forwarded");

  a_serial_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (io_cycle && !ser1_link_enable && io_addr >= `IO_SER1_LO) |-> !sel_first_serial_port)
    else $error("disabled serial port still claimed");

  a_route_update: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (io_wr && io_addr == `IO_CFG_DATA && cfg_index_ff == `CFG_ROUTE_IDX) |=> (route_ff == $past(io_wdata)))
    else $error("route write not effective next cycle");

  a_half_duplex: assert property (@(posedge ref_clk) disable iff (!rst_b)
    half_duplex_mode |-> (ser2_driver_enable != ser2_receiver_enable))
    else $error("half-duplex transceiver both ways");

  a_bank_lines: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (io_wr && io_addr == `IO_UTILITY) |=> (socket_bank == $past(io_wdata[3:0])))
    else $error("bank lines did not follow utility write");

  a_video_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_cycle && mem_addr >= `MEM_VIDEO_BASE && mem_addr <= `MEM_VIDEO_LAST)
      |-> (sel_expansion_mem != route_ff[`ROUTE_VIDEO_BIT]))
    else $error("display memory window misrouted");

  a_high_dram: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mem_cycle && mem_addr >= `MEM_HIGH_DRAM && mem_addr <= `MEM_HIGH_LAST) |-> (sel_dram == dram_large))
    else $error("high DRAM window misrouted");

  a_mem_onehot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mem_cycle |-> $onehot({sel_dram, sel_boot_rom, sel_second_socket, sel_expansion_mem}))
    else $error("memory cycle not routed to exactly one target");

  a_serial_to_bus: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (io_cycle && !ser2_link_enable && io_addr >= `IO_SER2_LO && io_addr <= `IO_SER2_HI) |-> sel_expansion_io)
    else $error("disabled serial range not forwarded");

  // A pin level must be seen by both late stages before the synchronised copy may follow it.
  sequence s_rx_settled;
    (rx_s2_ff == rx_s3_ff);
  endsequence

  a_rxd_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_rx_settled |=> (rxd_ff == $past(rx_s3_ff)))
    else $error("receive line did not follow settled stages");

endmodule : board_address_decoder

// File: bench/host_bus_model.sv
// Processor bus model that presents memory and I/O cycles to the board address decoder.
// Assumes the bench clock drives ref_clk; every cycle starts 2 ns after a rising edge.
module host_bus_model (
  input  wire logic        ref_clk,
  output logic      [19:0] mem_addr,
  output logic             mem_cycle,
  output logic      [9:0]  io_addr,
  output logic             io_cycle,
  output logic             io_write,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    mem_addr  = 20'h00000;
    mem_cycle = 1'b0;
    io_addr   = 10'h000;
    io_cycle  = 1'b0;
    io_write  = 1'b0;
    io_wdata  = 8'h00;
  end

  // A released bus shows the inverse of its last value so a stale address never looks valid.
  task automatic io_end();
    @(posedge ref_clk);
    #2;
    io_cycle = 1'b0;
    io_write = 1'b0;
    io_addr  = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : io_end

  task automatic io_probe(input logic [9:0] a);
    @(posedge ref_clk);
    #2;
    io_cycle = 1'b1;
    io_write = 1'b0;
    io_addr  = a;
  endtask : io_probe

  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    io_cycle = 1'b1;
    io_write = 1'b1;
    io_addr  = a;
    io_wdata = d;
    io_end();
  endtask : io_wr

  task automatic io_rd(input logic [9:0] a, output logic [7:0] d);
    io_probe(a);
    @(posedge ref_clk);
    d = io_rdata;
    #2;
    io_cycle = 1'b0;
    io_addr  = ~io_addr;
  endtask : io_rd

  task automatic mem_go(input logic [19:0] a);
    @(posedge ref_clk);
    #2;
    mem_cycle = 1'b1;
    mem_addr  = a;
  endtask : mem_go

  task automatic mem_end();
    @(posedge ref_clk);
    #2;
    mem_cycle = 1'b0;
    mem_addr  = ~mem_addr;
  endtask : mem_end
endmodule : host_bus_model

// File: bench/board_address_decoder_test.sv
// Self-checking bench for the board address decoder, compared with an integer model.
// Assumes the design files and the configuration header are compiled first.
`include "board_decode_cfg.svh"

module board_address_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk, rst_b, mem_cycle, io_cycle, io_write, io_claim;
  logic [19:0] mem_addr;
  logic [9:0]  io_addr;
  logic [7:0]  io_wdata, io_rdata, d;
  logic [7:0]  mem_sel, io_sel, ex;
  logic [3:0]  socket_bank;
  logic [1:0]  rxd_sync;
  logic        sel_dram, sel_boot_rom, sel_second_socket, sel_expansion_mem, sel_expansion_io;
  logic        sel_dma, sel_pic, sel_pit, sel_page, sel_first_serial_port, sel_second_serial_port;
  logic        ser1_link_enable, ser2_link_enable, dram_large, ser1_uart_irq, ser2_uart_irq;
  logic        irq4, irq3, ser2_uart_rts, half_duplex_mode, ser2_driver_enable, ser2_receiver_enable;
  logic        ser1_rxd_pin, ser2_rxd_pin;
  int          bad_count, total_checks, r, a, n;
  int          bounds[13] = '{'h7ffff, 'h80000, 'h9ffff, 'ha0000, 'hbffff, 'hc0000, 'hc7fff,
                              'hc8000, 'hcffff, 'hd0000, 'heffff, 'hf0000, 'hfffff};
  int          ios[36] = '{'h000, 'h00f, 'h010, 'h01f, 'h020, 'h021, 'h022, 'h023, 'h024, 'h03f,
                           'h040, 'h043, 'h044, 'h07f, 'h080, 'h08f, 'h090, 'h09f, 'h0a0, 'h0a1,
                           'h0a2, 'h0bf, 'h0c0, 'h0df, 'h0e0, 'h100, 'h2f7, 'h2f8, 'h2ff, 'h300,
                           'h3f7, 'h3f8, 'h3ff, 'h061, 'h092, 'h37c};

  board_address_decoder board_address_decoder_inst (.*);
  host_bus_model host_bus_model_inst (.*);

  assign mem_sel = {4'h0, sel_dram, sel_boot_rom, sel_second_socket, sel_expansion_mem};
  assign io_sel  = {1'b0, io_claim, sel_dma, sel_pic, sel_pit, sel_page,
                    sel_first_serial_port, sel_second_serial_port};

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Expected one-hot {dram, boot, socket, expansion} for a memory address.
  function automatic logic [3:0] exp_mem(int a, int r, int big);
    if (a >= 'hf0000) return 4'h4;
    if (a >= 'hd0000) return r[0] ? 4'h2 : 4'h1;
    if (a >= 'hc8000) return r[1] ? 4'h4 : 4'h1;
    if (a >= 'hc0000) return r[2] ? 4'h4 : 4'h1;
    if (a >= 'ha0000) return r[3] ? 4'h8 : 4'h1;
    if (a >= 'h80000) return big ? 4'h8 : 4'h1;
    return 4'h8;
  endfunction : exp_mem

  // Expected {claim, dma, pic, pit, page, serial1, serial2} for an I/O address.
  function automatic logic [6:0] exp_io(int a, int e1, int e2);
    logic [5:0] s;
    s[5] = (a <= 'h00f) || (a >= 'h0c0 && a <= 'h0df);
    s[4] = (a >= 'h020 && a <= 'h021) || (a >= 'h0a0 && a <= 'h0a1);
    s[3] = (a >= 'h040 && a <= 'h043);
    s[2] = (a >= 'h080 && a <= 'h08f);
    s[1] = (a >= 'h3f8 && a <= 'h3ff) && e1 != 0;
    s[0] = (a >= 'h2f8 && a <= 'h2ff) && e2 != 0;
    return {(s != 6'h00) || a == 'h022 || a == 'h023 || a == 'h061 || a == 'h092 || a == 'h37c, s};
  endfunction : exp_io

  initial begin
    #1250000;
    bad_count++;
    end_sim();
  end

  initial begin
    {rst_b, ser1_uart_irq, ser2_uart_irq, ser2_uart_rts, half_duplex_mode, dram_large} = 6'h00;
    {ser1_link_enable, ser2_link_enable, ser1_rxd_pin, ser2_rxd_pin} = 4'hf;
    n = $urandom(283);
    repeat (10) @(posedge ref_clk);
    #2;
    rst_b = 1'b1;
    chk({4'h0, socket_bank}, 8'h00, "bank reset");
    chk({6'h00, rxd_sync}, 8'h03, "rxd reset");
    host_bus_model_inst.io_wr(10'h022, `CFG_ROUTE_IDX);
    host_bus_model_inst.io_rd(10'h022, d);
    chk(d, `CFG_ROUTE_IDX, "index");
    host_bus_model_inst.io_rd(10'h023, d);
    chk(d, `ROUTE_RESET, "route reset");
    host_bus_model_inst.io_wr(10'h092, 8'ha5);
    host_bus_model_inst.io_rd(10'h092, d);
    chk(d, 8'ha5, "sys ctrl");
    ser1_uart_irq = 1'b1;
    host_bus_model_inst.io_wr(10'h061, 8'hfc);
    host_bus_model_inst.io_rd(10'h061, d);
    chk(d, 8'hfd, "ctrl status");
    host_bus_model_inst.io_wr(10'h37c, 8'h5a);
    chk({4'h0, socket_bank}, 8'h0a, "bank");
    host_bus_model_inst.io_rd(10'h37c, d);
    chk(d, 8'h00, "utility reads zero");
    host_bus_model_inst.io_wr(10'h022, 8'h02);
    host_bus_model_inst.io_wr(10'h023, 8'hff);
    host_bus_model_inst.io_rd(10'h023, d);
    chk(d, 8'h00, "other index");
    host_bus_model_inst.io_wr(10'h022, `CFG_ROUTE_IDX);
    host_bus_model_inst.io_rd(10'h023, d);
    chk(d, `ROUTE_RESET, "ignored write");
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      #2;
      {ser1_uart_irq, ser1_link_enable, ser2_uart_irq, ser2_link_enable} = i[3:0];
      #1;
      chk({6'h00, irq4, irq3}, {6'h00, i[3] & i[2], i[1] & i[0]}, "irq");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      #2;
      {half_duplex_mode, ser2_uart_rts} = i[1:0];
      #1;
      chk({6'h00, ser2_driver_enable, ser2_receiver_enable},
          {6'h00, !i[1] || i[0], !i[1] || !i[0]}, "duplex");
    end
    // Every address in the list is tried under all four link settings.
    foreach (ios[k]) begin
      for (int e = 0; e < 4; e++) begin
        {ser1_link_enable, ser2_link_enable} = e[1:0];
        host_bus_model_inst.io_probe(ios[k][9:0]);
        #1;
        ex = {1'b0, exp_io(ios[k], e[1], e[0])};
        chk(io_sel, ex, "io decode");
        chk({7'h00, sel_expansion_io}, {7'h00, !ex[6]}, "io expansion");
        host_bus_model_inst.io_end();
      end
    end
    r = `ROUTE_RESET;
    for (int it = 0; it < 16; it++) begin
      if (it > 0) begin
        r = $urandom & 'h0f;
        host_bus_model_inst.io_wr(10'h023, r[7:0]);
      end
      dram_large = $urandom & 1;
      for (int j = 0; j < 21; j++) begin
        a = (j < 13) ? bounds[j] : ($urandom & 'hfffff);
        host_bus_model_inst.mem_go(a[19:0]);
        #1;
        ex = {4'h0, exp_mem(a, r, dram_large)};
        chk(mem_sel, ex, "mem decode");
      end
      host_bus_model_inst.mem_end();
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      #2;
      {ser1_rxd_pin, ser2_rxd_pin} = $urandom & 3;
      a = (rxd_sync !== {ser2_rxd_pin, ser1_rxd_pin});
      n = 0;
      while (n < 8 && rxd_sync !== {ser2_rxd_pin, ser1_rxd_pin}) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      chk({6'h00, rxd_sync}, {6'h00, ser2_rxd_pin, ser1_rxd_pin}, "rxd sync");
      chk(n[7:0], (a != 0) ? 8'h04 : 8'h00, "rxd latency");
    end
    end_sim();
  end
endmodule : board_address_decoder_test
